// >>> src/eerd_ctrl.sv
// Command side of a serial EEPROM: array and status reads, pause, write
// enable latch and the self-timed programming cycle.
// Assumes pins sampled synchronously to clk_sys, far slower than it, and
// reset driven by the power-on detector.
`timescale 1ns/10ps
// Notes on behaviour
// - Addressed byte starts on serial output right after last address bit.
// - Read pointer advances by one per byte; next address byte follows.
// - Pointer past top address wraps to zero; reading runs on forever.
// - Raising select ends a read; output stops and logic goes idle.
// - After status code, the status byte is shifted out.
// - Status read accepted always, also while programming, with live bits.
// - While paused, output is high impedance and serial input ignored.
// - Power-on detector releases into standby, forces reset on brown-out.
// - After power-up, writing is disabled and device is in standby.
// - Completed byte or page write clears the write enable latch.
// - Programming starts only on select rising after whole bytes.
// - Array access during programming is ignored; programming continues.
// - Unknown codes are ignored and output stays high impedance.
// - Codes: array read 03, status read 05, write enable 06.
// - Only the low 13 address bits select a byte.
// - Status bit zero reads 1 while programming, 0 when ready.
// - Serial clock may idle low or high (modes 0,0 and 1,1).
module eerd_ctrl #(
    parameter int unsigned WRITE_CYCLE_NS = 5000000
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire eerd_pkg::eerd_pin_in_t pins,
    output logic                       so_d,
    output logic                       so_oe
);
    import eerd_pkg::*;

    localparam int unsigned WC_CYCLES =
        (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    eerd_state_t             state_q;
    logic                    sclk_q;
    logic                    cs_n_q;
    logic [4:0]              bit_cnt_q;
    logic [7:0]              sr_q;
    logic [14:0]             addr_q;
    logic [ARRAY_ADDR_W-1:0] ptr_q;
    logic [7:0]              out_sr_q;
    logic [2:0]              out_cnt_q;
    logic                    out_live_q;
    logic                    arm_set_q;
    logic                    arm_clr_q;
    logic                    write_enable_latch_q;
    logic                    busy_q;
    logic [31:0]             wc_cnt_q;
    logic [PAGE_BYTES-1:0]   pmask_q;
    logic [7:0]              pbuf_q [PAGE_BYTES];
    logic [7:0]              mem_q [ARRAY_DEPTH];
    logic [7:0]              status_byte;
    logic                    buf_in_ready;
    logic                    buf_out_valid;
    logic [7:0]              buf_out_data;
    logic                    op_is_write_q;

    // Edges count only while selected and not paused, so a pause freezes
    // the whole frame and serial input is ignored.
    wire       active    = ~pins.cs_n & pins.hold_n;
    wire       rise      = active & pins.sclk & ~sclk_q;
    wire       fall      = active & ~pins.sclk & sclk_q;
    wire       cs_rise   = pins.cs_n & ~cs_n_q;
    wire [7:0] in_bits   = {sr_q[6:0], pins.si};
    wire       op_done   = rise && state_q == ST_CMD
                           && bit_cnt_q == LAST_OP_BIT;
    wire       addr_done = rise && state_q == ST_ADDR
                           && bit_cnt_q == LAST_ADDR_BIT;
    wire       data_done = rise && state_q == ST_WDATA
                           && bit_cnt_q == LAST_DATA_BIT;
    wire       sending   = state_q == ST_READ || state_q == ST_STAT;
    wire       load_out  = fall && sending && out_cnt_q == 3'h0;
    wire       push      = state_q == ST_READ && buf_in_ready;
    wire       pop       = load_out && state_q == ST_READ;
    wire       wc_end    = busy_q && wc_cnt_q == 32'h0;
    wire       start_wc  = cs_rise && state_q == ST_WDATA
                           && bit_cnt_q == 5'h00 && |pmask_q
                           && write_enable_latch_q && !busy_q;

    // Status reads bypass the busy check; array codes are refused while
    // programming; unknown codes fall into the ignore state.
    wire is_array = in_bits == OP_ARRAY_READ || in_bits == OP_ARRAY_WRITE;
    wire eerd_state_t cmd_next =
        (in_bits == OP_STATUS_READ) ? ST_STAT :
        (busy_q || !is_array)       ? ST_IGNORE : ST_ADDR;

    always_comb begin
        status_byte                = 8'h00;
        status_byte[STAT_BUSY_POS] = busy_q;
        status_byte[STAT_WEL_POS]  = write_enable_latch_q;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= pins.sclk;
            cs_n_q <= pins.cs_n;
        end
    end

    // Frame sequencer; select high always returns it to idle.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 5'h00;
            sr_q      <= 8'h00;
            addr_q    <= 15'h0000;
            arm_set_q <= 1'b0;
            arm_clr_q <= 1'b0;
        end else if (pins.cs_n) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 5'h00;
            arm_set_q <= 1'b0;
            arm_clr_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            state_q <= ST_CMD;
        end else if (rise) begin
            sr_q      <= in_bits;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (op_done || addr_done || data_done) begin
                bit_cnt_q <= 5'h00;
            end
            if (op_done) begin
                state_q   <= cmd_next;
                arm_set_q <= in_bits == OP_WRITE_ENABLE && !busy_q;
                arm_clr_q <= in_bits == OP_WRITE_DISABLE && !busy_q;
            end
            if (state_q == ST_ADDR) begin
                addr_q <= in_bits[0] ? {addr_q[13:0], 1'b1}
                                     : {addr_q[13:0], 1'b0};
            end
            if (addr_done) begin
                state_q <= op_is_write_q ? ST_WDATA : ST_READ;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            op_is_write_q <= 1'b0;
        end else if (op_done) begin
            op_is_write_q <= in_bits == OP_ARRAY_WRITE;
        end
    end

    // Byte pointer: loaded from the low 13 address bits, advanced per byte
    // fetched, wrapping by its own width; writes roll within the page.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ptr_q <= '0;
        end else if (addr_done) begin
            ptr_q <= {addr_q[11:0], pins.si};
        end else if (push) begin
            ptr_q <= ptr_q + 13'h0001;
        end else if (data_done) begin
            ptr_q[PAGE_OFS_W-1:0] <= ptr_q[PAGE_OFS_W-1:0] + 6'h01;
        end
    end

    eerd_buf2 #(
        .WIDTH     (8)
    ) u_prefetch (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clear     (state_q != ST_READ),
        .in_valid  (state_q == ST_READ),
        .in_ready  (buf_in_ready),
        .in_data   (mem_q[ptr_q]),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data)
    );

    // Output shifter: loads a byte on the first falling edge of each byte
    // slot and shifts MSB first on the rest.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_sr_q   <= 8'h00;
            out_cnt_q  <= 3'h0;
            out_live_q <= 1'b0;
        end else if (pins.cs_n) begin
            out_cnt_q  <= 3'h0;
            out_live_q <= 1'b0;
        end else if (fall && sending) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == 3'h0) begin
                out_live_q <= 1'b1;
                out_sr_q   <= (state_q == ST_STAT) ? status_byte
                                                   : buf_out_data;
            end else begin
                out_sr_q <= {out_sr_q[6:0], 1'b0};
            end
        end
    end

    assign so_d  = out_sr_q[7];
    assign so_oe = active && sending && out_live_q;

    // Page capture, latch and the self-timed programming cycle.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            write_enable_latch_q <= WEL_RESET;
            busy_q               <= BUSY_RESET;
            wc_cnt_q             <= 32'h0;
            pmask_q              <= '0;
        end else begin
            if (cs_rise && arm_set_q) begin
                write_enable_latch_q <= 1'b1;
            end
            if (cs_rise && arm_clr_q) begin
                write_enable_latch_q <= 1'b0;
            end
            if (addr_done && !busy_q) begin
                pmask_q <= '0;
            end
            if (data_done) begin
                pbuf_q[ptr_q[PAGE_OFS_W-1:0]]  <= in_bits;
                pmask_q[ptr_q[PAGE_OFS_W-1:0]] <= 1'b1;
            end
            if (start_wc) begin
                busy_q   <= 1'b1;
                wc_cnt_q <= 32'(WC_CYCLES - 1);
            end else if (wc_end) begin
                busy_q               <= 1'b0;
                write_enable_latch_q <= 1'b0;
                pmask_q              <= '0;
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pmask_q[i]) begin
                        mem_q[{ptr_q[ARRAY_ADDR_W-1:PAGE_OFS_W],
                               6'(i)}] <= pbuf_q[i];
                    end
                end
            end else if (busy_q) begin
                wc_cnt_q <= wc_cnt_q - 32'h1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_wc_armed;
        start_wc;
    endsequence
    sequence s_wc_busy;
        busy_q [*2];
    endsequence

    property p_idle_quiet;
        pins.cs_n |-> !so_oe ##1 state_q == ST_IDLE;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Output driven or not idle with select high.");

    property p_pause_hiz;
        !pins.hold_n |-> !so_oe && $stable(bit_cnt_q);
    endproperty
    a_pause_hiz: assert property (p_pause_hiz)
        else $error("Output driven or bits taken while paused.");

    property p_ignore_hiz;
        state_q == ST_IGNORE |-> !so_oe;
    endproperty
    a_ignore_hiz: assert property (p_ignore_hiz)
        else $error("Output driven after an ignored code.");

    property p_ptr_step;
        push |=> ptr_q == $past(ptr_q) + 13'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("Read pointer did not advance by one.");

    property p_ptr_wrap;
        push && ptr_q == 13'h1fff |=> ptr_q == 13'h0000;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap)
        else $error("Read pointer did not wrap to zero.");

    property p_busy_only_on_select;
        $rose(busy_q) |-> $past(cs_rise);
    endproperty
    a_busy_only_on_select: assert property (p_busy_only_on_select)
        else $error("Programming began without select rising.");

    property p_latch_cleared;
        $fell(busy_q) |-> !write_enable_latch_q;
    endproperty
    a_latch_cleared: assert property (p_latch_cleared)
        else $error("Write enable latch still set after programming.");

    property p_status_busy;
        load_out && state_q == ST_STAT |=> out_sr_q[0] == $past(busy_q);
    endproperty
    a_status_busy: assert property (p_status_busy)
        else $error("Status busy bit differs from programming state.");

    property p_array_refused;
        op_done && busy_q && in_bits == OP_ARRAY_READ
            |=> state_q == ST_IGNORE;
    endproperty
    a_array_refused: assert property (p_array_refused)
        else $error("Array read accepted while programming.");

    property p_status_always;
        op_done && in_bits == OP_STATUS_READ |=> state_q == ST_STAT;
    endproperty
    a_status_always: assert property (p_status_always)
        else $error("Status read not accepted.");

    property p_read_starts;
        addr_done && !op_is_write_q |=> state_q == ST_READ;
    endproperty
    a_read_starts: assert property (p_read_starts)
        else $error("Read did not begin after last address bit.");

    property p_change_on_fall;
        $changed(out_sr_q) |-> $past(fall);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall)
        else $error("Output bit changed away from a falling edge.");

    property p_wc_runs;
        s_wc_armed |=> s_wc_busy;
    endproperty
    a_wc_runs: assert property (p_wc_runs)
        else $error("Programming cycle did not run after start.");

endmodule : eerd_ctrl

// >>> src/eerd_pkg.sv
// Shared constants and types for the serial EEPROM command logic.
// Assumes one system clock at 100 MHz and pins already in that domain.
package eerd_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Command codes of the serial protocol.
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02;

    // Array geometry.
    localparam int unsigned ARRAY_ADDR_W = 13;
    localparam int unsigned PAGE_OFS_W   = 6;
    localparam int unsigned ARRAY_DEPTH  = 8192;
    localparam int unsigned PAGE_BYTES   = 64;

    // Bit counter values that close each phase of a frame.
    localparam logic [4:0] LAST_OP_BIT   = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h0f;
    localparam logic [4:0] LAST_DATA_BIT = 5'h07;

    // Status byte layout and reset values.
    localparam int unsigned STAT_BUSY_POS = 0;
    localparam int unsigned STAT_WEL_POS  = 1;
    localparam logic        WEL_RESET     = 1'b0;
    localparam logic        BUSY_RESET    = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_READ,
        ST_STAT,
        ST_WDATA,
        ST_IGNORE
    } eerd_state_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
        logic hold_n;
    } eerd_pin_in_t;

endpackage : eerd_pkg

// >>> src/eerd_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a synchronous active-high reset and a synchronous clear.
`timescale 1ns/10ps
module eerd_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot_q [2];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = slot_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (reset || clear) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                slot_q[wr_q] <= in_data;
                wr_q         <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

endmodule : eerd_buf2

// >>> tb/eerd_host.sv
// Host model that drives select, serial clock, data and pause pins.
// Assumes the device samples the pins on clk_sys and drives so_d, so_oe.
`timescale 1ns/10ps
module eerd_host (
    input  wire logic              clk_sys,
    input  wire logic              so_d,
    input  wire logic              so_oe,
    output eerd_pkg::eerd_pin_in_t pins
);
    import eerd_pkg::*;
    logic idle_hi;
    int   oe_hits;
    int   hold_leaks;
    initial begin
        pins       = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, hold_n: 1'b1};
        idle_hi    = 1'b0;
        oe_hits    = 0;
        hold_leaks = 0;
    end
    // Pins change one step after the edge so the device never races them.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic start(input logic mode_hi);
        idle_hi   = mode_hi;
        pins.sclk = mode_hi;
        tick(3);
        pins.cs_n = 1'b0;
        oe_hits   = 0;
        tick(3);
    endtask : start
    // The serial clock keeps running during the pause to prove it is ignored.
    task automatic pause();
        logic s;
        s           = pins.si;
        pins.hold_n = 1'b0;
        for (int k = 0; k < 14; k++) begin
            pins.si   = ~pins.si;
            pins.sclk = k[1];
            tick(1);
            if (so_oe !== 1'b0) hold_leaks++;
        end
        pins.si     = s;
        pins.hold_n = 1'b1;
        tick(3);
    endtask : pause
    task automatic xfer(input logic [7:0] tx, input int hold_bit,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.sclk = 1'b0;
            pins.si   = tx[i];
            tick(3);
            if (i == hold_bit) pause();
            rx[i] = so_d;
            if (so_oe === 1'b1) oe_hits++;
            pins.sclk = 1'b1;
            tick(3);
        end
    endtask : xfer
    task automatic stop();
        pins.sclk = idle_hi;
        tick(3);
        pins.cs_n = 1'b1;
        pins.si   = ~pins.si;
        tick(3);
    endtask : stop
endmodule : eerd_host

// >>> tb/tb.sv
// Self-checking bench for the serial EEPROM command logic and its buffer.
// Assumes the host model in eerd_host and a 100 MHz clk_sys.
`timescale 1ns/10ps
module tb;
    import eerd_pkg::*;
    logic         clk_sys;
    logic         reset;
    logic         so_d;
    logic         so_oe;
    eerd_pin_in_t pins;
    int           miscompares;
    int           samples_checked;
    int           seed;
    logic [7:0]   mem [int];
    logic [7:0]   rx;
    logic [7:0]   op;
    logic [7:0]   q [$];

    eerd_ctrl #(.WRITE_CYCLE_NS(2000)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .pins(pins),
        .so_d(so_d), .so_oe(so_oe));
    eerd_host u_host (
        .clk_sys(clk_sys), .so_d(so_d), .so_oe(so_oe), .pins(pins));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checked=%0d mismatched=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic cmd(input logic [7:0] c, input logic mode_hi);
        u_host.start(mode_hi);
        u_host.xfer(c, -1, rx);
    endtask : cmd
    task automatic stat_read(input logic mode_hi, output logic [7:0] st);
        cmd(OP_STATUS_READ, mode_hi);
        u_host.xfer(8'h00, -1, st);
        u_host.stop();
    endtask : stat_read
    task automatic wr_page(input logic [15:0] a, input int n);
        logic [7:0] d;
        cmd(OP_WRITE_ENABLE, 1'b0);
        u_host.stop();
        cmd(OP_ARRAY_WRITE, 1'b0);
        u_host.xfer(a[15:8], -1, rx);
        u_host.xfer(a[7:0], -1, rx);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            mem[{a[12:6], 6'(a[5:0] + i)}] = d;
            u_host.xfer(d, -1, rx);
        end
        u_host.stop();
    endtask : wr_page
    task automatic wait_ready();
        logic [7:0] st;
        for (int i = 0; i < 40; i++) begin
            stat_read(1'b1, st);
            if (st !== 8'h03) break;
        end
        check(st, 8'h00);
    endtask : wait_ready
    task automatic rd(input logic [15:0] a, input int n, input logic mode_hi,
                      input int hold_at);
        cmd(OP_ARRAY_READ, mode_hi);
        u_host.xfer(a[15:8], -1, rx);
        u_host.xfer(a[7:0], -1, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'h00, (i == 2) ? hold_at : -1, rx);
            check(rx, mem[13'(a + i)]);
        end
        u_host.stop();
        check({7'h00, so_oe}, 8'h00);
    endtask : rd

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        miscompares++;
        complete_run();
    end
    initial begin
        reset           = 1'b1;
        miscompares     = 0;
        samples_checked = 0;
        seed            = 39;
        repeat (6) @(posedge clk_sys);
        #1 reset = 1'b0;
        stat_read(1'b0, rx);
        check(rx, 8'h00);
        cmd(OP_WRITE_ENABLE, 1'b1);
        u_host.stop();
        stat_read(1'b1, rx);
        check(rx, 8'h02);
        cmd(OP_WRITE_DISABLE, 1'b0);
        u_host.stop();
        stat_read(1'b0, rx);
        check(rx, 8'h00);
        $display("test power_up done");
        wr_page(16'hfffe, 4);
        stat_read(1'b0, rx);
        check(rx, 8'h03);
        cmd(OP_ARRAY_READ, 1'b0);
        u_host.xfer(8'h00, -1, rx);
        u_host.xfer(8'h00, -1, rx);
        u_host.xfer(8'h00, -1, rx);
        u_host.stop();
        check(8'(u_host.oe_hits), 8'h00);
        wait_ready();
        wr_page(16'h2000, 2);
        wait_ready();
        $display("test write_busy done");
        rd(16'hfffe, 4, 1'b1, 4);
        check(8'(u_host.hold_leaks), 8'h00);
        rd(16'h1fc0, 2, 1'b0, -1);
        $display("test read_wrap_pause done");
        for (int k = 0; k < 6; k++) begin
            op = 8'($random(seed));
            if (op inside {[8'h01:8'h06]}) op = 8'hff;
            cmd(op, k[0]);
            u_host.xfer(8'h00, -1, rx);
            u_host.xfer(8'h00, -1, rx);
            u_host.stop();
            check(8'(u_host.oe_hits), 8'h00);
        end
        $display("test bad_codes done");
        cmd(OP_WRITE_ENABLE, 1'b0);
        u_host.stop();
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        stat_read(1'b0, rx);
        check(rx, 8'h00);
        $display("test brown_out done");
        // Pauses stall the reader while the prefetch buffer holds bytes.
        for (int i = 0; i < 4; i++) begin
            q.push_back(mem[13'(16'h1ffe + i)]);
        end
        cmd(OP_ARRAY_READ, 1'b0);
        u_host.xfer(8'h1f, -1, rx);
        u_host.xfer(8'hfe, -1, rx);
        for (int i = 0; i < 4; i++) begin
            u_host.xfer(8'h00, (i < 2) ? 7 - 2 * i : -1, rx);
            check(rx, q.pop_front());
        end
        check(8'(q.size()), 8'h00);
        u_host.stop();
        check({7'h00, so_oe}, 8'h00);
        check(8'(u_host.hold_leaks), 8'h00);
        $display("test buffer done");
        complete_run();
    end
endmodule : tb
